// file: hw/trim_loader_pkg.sv
// Constants, field layout and carrier types for the trim register loader.
// Assumes a 20 MHz control clock; the serial clock is a separate domain.
package trim_loader_pkg;

  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned NV_BITS         = 128;
  localparam int unsigned WORD_W          = 16;
  localparam int unsigned COEF_W          = 12;
  localparam int unsigned ADDR_W          = 7;
  localparam int unsigned LOAD_WORDS      = 5;
  localparam int unsigned CMD_LSB         = 12;

  // Refresh about 400 times per second while writes are permitted
  localparam int unsigned REFRESH_RATE_HZ = 400;
  localparam int unsigned REFRESH_CYCLES  = CLK_HZ / REFRESH_RATE_HZ;

  // Read bit appears on the data line 200 us after the command
  localparam int unsigned READ_DELAY_NS   = 200_000;
  localparam int unsigned READ_CYCLES     =
    (READ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Wakeup pattern 1,0,1,0,U,0 in arrival order, bit 0 first
  localparam int unsigned WAKE_BITS       = 6;
  localparam int unsigned WAKE_U_POS      = 4;
  localparam logic [5:0]  WAKE_EXPECT     = 6'h05;
  localparam logic [5:0]  WAKE_CARE       = 6'h2F;

  // Command field codes
  localparam logic [3:0] CMD_NOP         = 4'h0;
  localparam logic [3:0] CMD_ERASE       = 4'h1;
  localparam logic [3:0] CMD_WRITE_BEGIN = 4'h2;
  localparam logic [3:0] CMD_READ        = 4'h3;
  localparam logic [3:0] CMD_WRITE_END   = 4'h5;
  localparam logic [3:0] CMD_REG_CFG     = 4'h8;
  localparam logic [3:0] CMD_REG_OFF     = 4'h9;
  localparam logic [3:0] CMD_REG_OFFTC   = 4'hA;
  localparam logic [3:0] CMD_REG_SPAN    = 4'hB;
  localparam logic [3:0] CMD_REG_SPANTC  = 4'hC;

  // Configuration word bit positions
  localparam int unsigned CFG_OTC_POL     = 0;
  localparam int unsigned CFG_OFF_POL     = 1;
  localparam int unsigned CFG_GAIN_MSB    = 2;
  localparam int unsigned CFG_GAIN_MID    = 3;
  localparam int unsigned CFG_GAIN_LSB    = 4;
  localparam int unsigned CFG_RES_SEL     = 7;
  localparam int unsigned CFG_IRO_SIGN    = 8;
  localparam int unsigned CFG_IRO_MSB     = 9;
  localparam int unsigned CFG_IRO_MID     = 10;
  localparam int unsigned CFG_IRO_LSB     = 11;

  // Tags of the loaded words; word 0 is configuration
  localparam logic [LOAD_WORDS-1:0][3:0] WORD_TAGS = {4'hC, 4'hB, 4'hA, 4'h9, 4'h8};

  typedef logic [LOAD_WORDS-1:0][COEF_W-1:0] coef_bank_t;

  typedef struct packed {
    logic       offset_tempco_polarity;
    logic       offset_polarity;
    logic [2:0] gain_select;
    logic       source_resistor_on;
    logic       tempco_resistor_on;
    logic       input_offset_trim_sign;
    logic [2:0] input_offset_trim_mag;
  } trim_cfg_t;

  typedef struct packed {
    trim_cfg_t          cfg;
    logic [COEF_W-1:0]  offset;
    logic [COEF_W-1:0]  offset_tempco;
    logic [COEF_W-1:0]  span;
    logic [COEF_W-1:0]  span_tempco;
  } trim_out_t;

  typedef enum logic [1:0] {LINK_LISTEN, LINK_WORDS, LINK_IGNORE} link_phase_t;

endpackage : trim_loader_pkg

// file: hw/nv_word_check.sv
// One stored word: splits tag from coefficient and checks the tag.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module nv_word_check
  import trim_loader_pkg::*;
#(
  parameter logic [3:0] TAG = 4'h0
) (
  input  wire logic [WORD_W-1:0] word_i,
  output logic      [COEF_W-1:0] data_o,
  output logic                   tag_ok_o
);

  assign data_o   = word_i[COEF_W-1:0];
  assign tag_ok_o = (word_i[WORD_W-1:COEF_W] == TAG);

endmodule : nv_word_check

// file: hw/eeprom_trim_register_loader.sv
// Trim store, serial command receiver and register loader.
// Serial lines are framed by the host around serial_clock_i; the rest runs on mclk_i.
// Functional notes
// - Store holds 128 bits as eight 16-bit words, bit addressable.
// - Writes set one bit per operation at a 7-bit address.
// - Top four bits of each word are tags 8h..Ch, else zero.
// - Loads from the store check tags; wrong tags stop them, but direct load commands skip the check.
// - Configuration bit positions are fixed for polarity, gain and input trim.
// - Configuration bit 7 low disconnects both internal resistors.
// - Words one to four hold 12-bit coefficients, MSB at bit 11.
// - Each coefficient output has its own register backed by a store word.
// - Two user words exist and never take part in loading.
// - Select low ignores the serial port and disables the analog output.
// - Select rising reloads registers unless update suppress is set.
// - Select falling ends programming and abandons the serial session.
// - Write permit low blocks erase, write and periodic refresh.
// - Write permit high refreshes about 400 times a second and allows writes.
// - An opened serial session suspends periodic refresh.
// - Host drives serial clock; data is sampled on its rising edges.
// - First six bits must be 1,0,1,0,U,0, else ignore until next select.
// - U set keeps current registers on later select rising edges.
// - After wakeup, 16-bit words arrive LSB first: 12 data, 4 command.
// - Reset clears registers and the store to zero, then tries a tag-checked load from the store.
`timescale 1ns/1ps
module eeprom_trim_register_loader
  import trim_loader_pkg::*;
#(
  parameter int unsigned REFRESH_CYCLES_P = REFRESH_CYCLES
) (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic serial_clock_i,
  input  wire logic select_i,
  input  wire logic write_permit_i,
  input  wire logic serial_data_line_i,
  output logic      serial_data_line_o,
  output logic      serial_data_line_oe_o,
  output logic      analog_out_enable_o,
  output trim_out_t trim_o
);

  typedef struct packed {
    link_phase_t        phase;
    logic [3:0]         cnt;
    logic [WORD_W-1:0]  shift;
    logic [WORD_W-1:0]  hold;
    logic               u_hold;
    logic               word_tgl;
    logic               open_tgl;
  } link_state_t;

  typedef struct packed {
    logic               sel_s1;
    logic               sel_s2;
    logic               sel_q;
    logic               wp_s1;
    logic               wp_s2;
    logic               wtg_s1;
    logic               wtg_s2;
    logic               wtg_q;
    logic               otg_s1;
    logic               otg_s2;
    logic               otg_q;
    logic               session;
    logic               suppress;
    logic               load_pend;
    logic [15:0]        refresh_cnt;
    logic               read_busy;
    logic [11:0]        read_cnt;
    logic [ADDR_W-1:0]  read_addr;
    logic               serial_data_line;
    logic               dio_oe;
    logic [NV_BITS-1:0] nv;
    coef_bank_t         stage;
    coef_bank_t         live;
  } ctl_state_t;

  link_state_t       l_q;
  link_state_t       l_d;
  ctl_state_t        c_q;
  ctl_state_t        c_d;
  logic              lrst_s1;
  logic              lrst_s2;
  coef_bank_t        loaded;
  logic [LOAD_WORDS-1:0] tag_ok;
  logic              all_ok;
  logic              sel_rise;
  logic              sel_fall;
  logic              word_evt;
  logic              open_evt;
  logic              load_now;
  logic [3:0]        cmd;
  logic [ADDR_W-1:0] addr;
  logic [COEF_W-1:0] wdata;

  // Link domain reset, released on serial clock edges
  always_ff @(posedge serial_clock_i) begin
    lrst_s1 <= rst_i;
    lrst_s2 <= lrst_s1;
  end

  // Select and data are framed by the host relative to the serial clock
  always_comb begin
    l_d = l_q;
    if (!select_i) begin
      l_d.phase = LINK_LISTEN;
      l_d.cnt   = 4'h0;
    end else begin
      unique case (l_q.phase)
        LINK_LISTEN: begin
          if (WAKE_CARE[l_q.cnt[2:0]] &&
              serial_data_line_i != WAKE_EXPECT[l_q.cnt[2:0]]) begin
            l_d.phase = LINK_IGNORE;
          end else begin
            if (l_q.cnt == 4'(WAKE_U_POS)) begin
              l_d.u_hold = serial_data_line_i;
            end
            if (l_q.cnt == 4'(WAKE_BITS - 1)) begin
              l_d.phase    = LINK_WORDS;
              l_d.cnt      = 4'h0;
              l_d.open_tgl = ~l_q.open_tgl;
            end else begin
              l_d.cnt = l_q.cnt + 4'h1;
            end
          end
        end
        LINK_WORDS: begin
          // LSB first, so each new bit enters at the top
          l_d.shift = {serial_data_line_i, l_q.shift[WORD_W-1:1]};
          if (l_q.cnt == 4'hF) begin
            l_d.hold     = l_d.shift;
            l_d.word_tgl = ~l_q.word_tgl;
            l_d.cnt      = 4'h0;
          end else begin
            l_d.cnt = l_q.cnt + 4'h1;
          end
        end
        LINK_IGNORE: begin
        end
        default: l_d.phase = LINK_IGNORE;
      endcase
    end
  end

  always_ff @(posedge serial_clock_i) begin
    if (lrst_s2) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // Tag check and extraction of the five loaded words, one pass
  for (genvar i = 0; i < LOAD_WORDS; i++) begin : g_word
    nv_word_check #(
      .TAG(WORD_TAGS[i])
    ) u_check (
      .word_i  (c_q.nv[i*WORD_W +: WORD_W]),
      .data_o  (loaded[i]),
      .tag_ok_o(tag_ok[i])
    );
  end
  assign all_ok = &tag_ok;

  assign sel_rise = c_q.sel_s2 && !c_q.sel_q;
  assign sel_fall = !c_q.sel_s2 && c_q.sel_q;
  assign word_evt = c_q.wtg_s2 != c_q.wtg_q;
  assign open_evt = c_q.otg_s2 != c_q.otg_q;
  // Hold word is stable for 15 serial clocks after its toggle
  assign cmd   = l_q.hold[WORD_W-1:CMD_LSB];
  assign addr  = l_q.hold[ADDR_W-1:0];
  assign wdata = l_q.hold[COEF_W-1:0];

  always_comb begin
    c_d        = c_q;
    load_now   = 1'b0;
    c_d.sel_s1 = select_i;
    c_d.sel_s2 = c_q.sel_s1;
    c_d.sel_q  = c_q.sel_s2;
    c_d.wp_s1  = write_permit_i;
    c_d.wp_s2  = c_q.wp_s1;
    c_d.wtg_s1 = l_q.word_tgl;
    c_d.wtg_s2 = c_q.wtg_s1;
    c_d.wtg_q  = c_q.wtg_s2;
    c_d.otg_s1 = l_q.open_tgl;
    c_d.otg_s2 = c_q.otg_s1;
    c_d.otg_q  = c_q.otg_s2;

    if (c_q.load_pend) begin
      load_now      = 1'b1;
      c_d.load_pend = 1'b0;
    end
    if (sel_rise && !c_q.suppress) begin
      load_now = 1'b1;
    end
    // Counter freezes while a session is open or writes are barred
    if (c_q.wp_s2 && !c_q.session) begin
      if (c_q.refresh_cnt == 16'h0000) begin
        load_now        = 1'b1;
        c_d.refresh_cnt = 16'(REFRESH_CYCLES_P - 1);
      end else begin
        c_d.refresh_cnt = c_q.refresh_cnt - 16'h0001;
      end
    end

    if (open_evt && c_q.sel_s2) begin
      c_d.session  = 1'b1;
      c_d.suppress = l_q.u_hold;
    end

    if (word_evt && c_q.session && c_q.sel_s2) begin
      unique case (cmd)
        CMD_ERASE: begin
          if (c_q.wp_s2) begin
            c_d.nv = '0;
          end
        end
        CMD_WRITE_BEGIN: begin
          if (c_q.wp_s2) begin
            c_d.nv[addr] = 1'b1;
          end
        end
        CMD_READ: begin
          c_d.read_busy = 1'b1;
          c_d.read_cnt  = 12'(READ_CYCLES);
          c_d.read_addr = addr;
        end
        CMD_REG_CFG:    c_d.stage[0] = wdata;
        CMD_REG_OFF:    c_d.stage[1] = wdata;
        CMD_REG_OFFTC:  c_d.stage[2] = wdata;
        CMD_REG_SPAN:   c_d.stage[3] = wdata;
        CMD_REG_SPANTC: c_d.stage[4] = wdata;
        4'h6, 4'h7, 4'hD, 4'hE, 4'hF: c_d.live = c_q.stage;
        default: begin
          // No-op, end of write and reserved codes
        end
      endcase
    end

    if (c_q.read_busy) begin
      if (c_q.read_cnt == 12'h001) begin
        c_d.read_busy = 1'b0;
        c_d.serial_data_line       = c_q.nv[c_q.read_addr];
        c_d.dio_oe    = 1'b1;
      end else begin
        c_d.read_cnt = c_q.read_cnt - 12'h001;
      end
    end

    if (sel_fall) begin
      c_d.session   = 1'b0;
      c_d.read_busy = 1'b0;
      c_d.dio_oe    = 1'b0;
    end

    // Whole bank or nothing, so no register is left half loaded
    if (load_now && all_ok) begin
      c_d.live = loaded;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      c_q           <= '0;
      c_q.load_pend <= 1'b1;
    end else begin
      c_q <= c_d;
    end
  end

  assign serial_data_line_o    = c_q.serial_data_line;
  assign serial_data_line_oe_o = c_q.dio_oe;
  assign analog_out_enable_o   = c_q.sel_s2;

  // Gain and trim magnitude are stored MSB at the lower address
  always_comb begin
    trim_o.cfg.offset_tempco_polarity = c_q.live[0][CFG_OTC_POL];
    trim_o.cfg.offset_polarity        = c_q.live[0][CFG_OFF_POL];
    trim_o.cfg.gain_select            = {c_q.live[0][CFG_GAIN_MSB],
                                         c_q.live[0][CFG_GAIN_MID],
                                         c_q.live[0][CFG_GAIN_LSB]};
    trim_o.cfg.source_resistor_on     = c_q.live[0][CFG_RES_SEL];
    trim_o.cfg.tempco_resistor_on     = c_q.live[0][CFG_RES_SEL];
    trim_o.cfg.input_offset_trim_sign = c_q.live[0][CFG_IRO_SIGN];
    trim_o.cfg.input_offset_trim_mag  = {c_q.live[0][CFG_IRO_MSB],
                                         c_q.live[0][CFG_IRO_MID],
                                         c_q.live[0][CFG_IRO_LSB]};
    trim_o.offset                     = c_q.live[1];
    trim_o.offset_tempco              = c_q.live[2];
    trim_o.span                       = c_q.live[3];
    trim_o.span_tempco                = c_q.live[4];
  end

  a_no_write_barred: assert property (@(posedge mclk_i) disable iff (rst_i)
    !c_q.wp_s2 |=> $stable(c_q.nv))
    else $error("store changed while write permit low");

  a_fall_ends_read: assert property (@(posedge mclk_i) disable iff (rst_i)
    sel_fall |=> !serial_data_line_oe_o && !c_q.session)
    else $error("session survived select fall");

  a_rise_reloads: assert property (@(posedge mclk_i) disable iff (rst_i)
    (sel_rise && !c_q.suppress && all_ok) |=> c_q.live == $past(loaded))
    else $error("select rise did not reload registers");

  a_suppress_keeps: assert property (@(posedge mclk_i) disable iff (rst_i)
    (sel_rise && c_q.suppress && !c_q.wp_s2 && !word_evt && !c_q.load_pend)
      |=> $stable(c_q.live))
    else $error("suppressed reload changed registers");

  a_bad_tag_holds: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!all_ok && !word_evt) |=> $stable(c_q.live))
    else $error("registers loaded from mistagged store");

  a_refresh_period: assert property (@(posedge mclk_i) disable iff (rst_i)
    (c_q.wp_s2 && !c_q.session && c_q.refresh_cnt == 16'h0000)
      |=> c_q.refresh_cnt == 16'(REFRESH_CYCLES_P - 1))
    else $error("refresh period not restarted");

  a_session_freeze: assert property (@(posedge mclk_i) disable iff (rst_i)
    c_q.session |=> $stable(c_q.refresh_cnt))
    else $error("refresh ran during session");

  a_reset_clears: assert property (@(posedge mclk_i) disable iff (rst_i)
    $fell(rst_i) |-> (c_q.live == '0 && c_q.load_pend))
    else $error("registers not cleared by reset");

  a_read_drives: assert property (@(posedge mclk_i) disable iff (rst_i)
    (c_q.read_busy && c_q.read_cnt == 12'h001 && c_q.sel_s2)
      |=> serial_data_line_oe_o && serial_data_line_o == $past(c_q.nv[c_q.read_addr]))
    else $error("read bit not driven after delay");

  a_wake_reject: assert property (@(posedge serial_clock_i) disable iff (lrst_s2)
    (l_q.phase == LINK_LISTEN && select_i && l_q.cnt == 4'h0 && !serial_data_line_i)
      |=> l_q.phase == LINK_IGNORE)
    else $error("bad wakeup bit accepted");

  a_word_framing: assert property (@(posedge serial_clock_i) disable iff (lrst_s2)
    (l_q.phase == LINK_WORDS && select_i && l_q.cnt == 4'hF) |=> $changed(l_q.word_tgl))
    else $error("16th bit did not complete a word");

endmodule : eeprom_trim_register_loader

// file: bench/trim_host_model.sv
// Host tester model driving serial clock, select and data of the trim loader.
// Assumes the bench resolves the shared data line from the loader's output enable.
`timescale 1ns/1ps
module trim_host_model (
  input  wire logic mclk_i,
  output logic      serial_clock_o,
  output logic      select_o,
  output logic      data_o
);
  initial begin
    serial_clock_o = 1'b0;
    select_o       = 1'b0;
    data_o         = 1'b1;
  end

  // Data moves while the clock is low, so it is stable at the rise
  task automatic pulse(input logic d);
    data_o = d;
    #7.5;
    serial_clock_o = 1'b1;
    #7.5;
    serial_clock_o = 1'b0;
  endtask : pulse

  task automatic frame(input logic [5:0] wake, input logic [15:0] words[$]);
    pulse(~data_o); // Edge with select low restarts the bit count
    @(posedge mclk_i);
    select_o <= 1'b1;
    repeat (3) @(posedge mclk_i);
    #3;
    for (int i = 0; i < 6; i++) pulse(wake[i]);
    foreach (words[w]) for (int b = 0; b < 16; b++) pulse(words[w][b]);
    data_o = ~data_o; // Released line must not look like a held bit
  endtask : frame

  task automatic close_frame();
    @(posedge mclk_i);
    select_o <= 1'b0;
  endtask : close_frame
endmodule : trim_host_model

// file: bench/eeprom_trim_register_loader_tb_top.sv
// Self-checking bench: loader against a reference model of store and registers.
// Assumes trim_host_model drives the serial lines; refresh period is shortened.
`timescale 1ns/1ps
module eeprom_trim_register_loader_tb_top;
  import trim_loader_pkg::*;
  localparam int         REF_P    = 200;
  localparam logic [3:0] LOADS[5] = '{4'h6, 4'h7, 4'hD, 4'hE, 4'hF};
  logic         mclk = 1'b0;
  logic         rst  = 1'b1;
  logic         wp   = 1'b0;
  logic         u_m  = 1'b0;
  logic         sclk, sel, host_d, dev_d, dev_oe, aout_en, line;
  logic [6:0]   addr;
  logic [127:0] nv_m, stg_nv, tgt;
  logic [15:0]  cmds[$];
  trim_out_t    trim, live_m;
  int           num_errors = 0;
  int           n_compared = 0;
  int           cycles     = 0;

  assign line = dev_oe ? dev_d : host_d;

  eeprom_trim_register_loader #(.REFRESH_CYCLES_P(REF_P)) i_eeprom_trim_register_loader (
    .mclk_i(mclk), .rst_i(rst), .serial_clock_i(sclk), .select_i(sel),
    .write_permit_i(wp), .serial_data_line_i(line), .serial_data_line_o(dev_d),
    .serial_data_line_oe_o(dev_oe), .analog_out_enable_o(aout_en), .trim_o(trim));

  trim_host_model i_trim_host_model (
    .mclk_i(mclk), .serial_clock_o(sclk), .select_o(sel), .data_o(host_d));

  initial begin
    forever #25 mclk = ~mclk;
  end

  function automatic trim_out_t from_store(input logic [127:0] nv);
    trim_out_t t;
    t.cfg = {nv[0], nv[1], nv[2], nv[3], nv[4], nv[7], nv[7],
             nv[8], nv[9], nv[10], nv[11]};
    t.offset        = nv[27:16];
    t.offset_tempco = nv[43:32];
    t.span          = nv[59:48];
    t.span_tempco   = nv[75:64];
    return t;
  endfunction : from_store

  function automatic logic tags_ok(input logic [127:0] nv);
    return nv[15:12] == 4'h8 && nv[31:28] == 4'h9 && nv[47:44] == 4'hA &&
           nv[63:60] == 4'hB && nv[79:76] == 4'hC;
  endfunction : tags_ok

  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test

  task automatic check_trim(input trim_out_t exp);
    n_compared++;
    if (trim !== exp) begin
      num_errors++;
      $display("unexpected trim at %0t: got %h exp %h", $time, trim, exp);
    end
  endtask : check_trim

  task automatic check_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected bit at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check_bit

  task automatic stage();
    for (int k = 0; k < 5; k++) cmds.push_back({CMD_REG_CFG + 4'(k), 12'($urandom)});
    cmds.push_back({CMD_NOP, 12'($urandom)});
    cmds.push_back({4'h4, 12'($urandom)});
  endtask : stage

  task automatic run(input logic [5:0] wake, input int hold);
    logic [15:0] w;
    if (!u_m && tags_ok(nv_m)) live_m = from_store(nv_m);
    i_trim_host_model.frame(wake, cmds);
    if ((wake & WAKE_CARE) == WAKE_EXPECT) begin
      u_m = wake[WAKE_U_POS];
      foreach (cmds[i]) begin
        w = cmds[i];
        case (w[15:12])
          CMD_ERASE: if (wp) nv_m = '0;
          CMD_WRITE_BEGIN: if (wp) nv_m[w[6:0]] = 1'b1;
          CMD_REG_CFG, CMD_REG_OFF, CMD_REG_OFFTC, CMD_REG_SPAN, CMD_REG_SPANTC:
            stg_nv[16 * (w[15:12] - 4'h8) +: 12] = w[11:0];
          4'h6, 4'h7, 4'hD, 4'hE, 4'hF: live_m = from_store(stg_nv);
          default: ;
        endcase
      end
    end
    cmds.delete();
    repeat (hold) @(posedge mclk);
  endtask : run

  task automatic end_frame();
    i_trim_host_model.close_frame();
    repeat (4) @(posedge mclk);
  endtask : end_frame

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    if (wp && tags_ok(nv_m)) live_m = from_store(nv_m);
  endtask : idle

  // Hang guard; the whole run needs about 23000 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      stop_test();
    end
  end

  initial begin
    nv_m   = '0;
    stg_nv = '0;
    live_m = '0;
    void'($urandom(4));
    repeat (4) i_trim_host_model.pulse(1'b0);
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    // Link side leaves reset only on serial edges, so give it some first
    repeat (3) i_trim_host_model.pulse(1'b0);
    repeat (6) @(posedge mclk);
    check_trim(live_m);
    check_bit(aout_en, 1'b0);
    $display("test reset done");
    // Config keeps reserved bits 5, 6 and resistor bit 7 low
    wp <= 1'b1;
    tgt = '0;
    tgt[15:0] = {4'h8, 12'($urandom) & 12'hF1F};
    for (int k = 1; k < 5; k++) tgt[16*k +: 16] = {4'h8 + 4'(k), 12'($urandom)};
    tgt[111:96] = {4'h0, 12'($urandom)};
    cmds.push_back({CMD_ERASE, 12'h000});
    for (int a = 0; a < 128; a++) begin
      if (tgt[a]) cmds.push_back({CMD_WRITE_BEGIN, 12'(a)});
    end
    cmds.push_back({CMD_WRITE_END, 12'h000});
    run(6'h05, 10);
    check_bit(aout_en, 1'b1);
    end_frame();
    check_bit(aout_en, 1'b0);
    idle(2 * REF_P + 20);
    check_trim(live_m);
    $display("test program done");
    for (int r = 0; r < 5; r++) begin
      addr = (r == 0) ? 7'h0F : (r == 1) ? 7'h0E : (r == 2) ? 7'h50 : 7'($urandom);
      cmds.push_back({CMD_READ, 5'($urandom), addr});
      run(6'h05, READ_CYCLES - 20);
      check_bit(dev_oe, 1'b0);
      repeat (40) @(posedge mclk);
      check_bit(dev_oe, 1'b1);
      check_bit(dev_d, nv_m[addr]);
      end_frame();
      check_bit(dev_oe, 1'b0);
    end
    $display("test readback done");
    wp <= 1'b0;
    foreach (LOADS[i]) begin
      stage();
      cmds.push_back({LOADS[i], 12'h000});
      run(6'h15, 10);
      check_trim(live_m);
      end_frame();
    end
    run(6'h15, 2);
    wp <= 1'b1;
    repeat (450) @(posedge mclk);
    check_trim(live_m);
    end_frame();
    idle(2 * REF_P + 20);
    check_trim(live_m);
    $display("test direct done");
    wp <= 1'b0;
    cmds.push_back({CMD_ERASE, 12'h000});
    cmds.push_back({CMD_WRITE_BEGIN, 12'h00E});
    stage();
    cmds.push_back({4'h6, 12'h000});
    run(6'h05, 10);
    check_trim(live_m);
    end_frame();
    run(6'h05, 10);
    check_trim(live_m);
    end_frame();
    stage();
    cmds.push_back({4'h6, 12'h000});
    run(6'h07, 10);
    check_trim(live_m);
    end_frame();
    // Wakeup that fails on its very first bit
    stage();
    cmds.push_back({4'h7, 12'h000});
    run(6'h2A, 10);
    check_trim(live_m);
    end_frame();
    $display("test permit done");
    wp <= 1'b1;
    cmds.push_back({CMD_WRITE_BEGIN, 12'h00E});
    stage();
    cmds.push_back({4'hF, 12'h000});
    run(6'h05, 10);
    end_frame();
    idle(2 * REF_P + 20);
    check_trim(live_m);
    $display("test tags done");
    stop_test();
  end
endmodule : eeprom_trim_register_loader_tb_top
